// ===== core/fbci_core.v
// cyclic image command interpreter of the fieldbus slave
`timescale 1ns/100ps
`include "fbci_defines.vh"

module fbci_core (
    ref_clk,
    srst,
    map86,
    out_valid,
    out_img,
    inst_err,
    disp_weight,
    status1,
    status2,
    float_data,
    restart_set,
    act_done,
    act_ok,
    act_err,
    act_req_ff,
    act_cmd_ff,
    busy_ff,
    in_img_ff
);
    input wire ref_clk;
    input wire srst;
    input wire map86;
    input wire out_valid;
    input wire [`FBCI_OUT_BITS-1:0] out_img;
    input wire [7:0] inst_err;
    input wire [47:0] disp_weight;
    input wire [15:0] status1;
    input wire [15:0] status2;
    input wire [`FBCI_FLT_BITS-1:0] float_data;
    input wire restart_set;
    input wire act_done;
    input wire act_ok;
    input wire [31:0] act_err;
    output reg act_req_ff;
    output reg [7:0] act_cmd_ff;
    output reg busy_ff;
    output reg [`FBCI_IN_BITS-1:0] in_img_ff;

    localparam ST_IDLE = 3'b001;
    localparam ST_WRITE = 3'b010;
    localparam ST_ACT = 3'b100;

    reg [2:0] state_ff;
    reg [7:0] prev_cmd_ff;
    reg [7:0] ack_ff;
    reg [31:0] cmd_err_ff;
    reg [15:0] win_base_ff;
    reg restart_ff;
    reg [3:0] wr_left_ff;
    reg [15:0] wr_addr_ff;
    reg [`FBCI_WDAT_BITS-1:0] wdat_ff;
    reg [1:0] rd_idx_ff;
    reg [1:0] rd_slot_ff;
    reg rd_ok_ff;
    wire [15:0] rd_data;
    wire [15:0] win_w [0:`FBCI_WIN_REGS-1];

    // ==========================================================
    // field extraction, byte 0 at the top of the image
    wire [7:0] cmd = out_img[159:152];
    wire [3:0] cnt = out_img[147:144];
    wire cnt_hi = |out_img[151:148];
    wire [15:0] start = out_img[143:128];
    wire [16:0] start_off = {1'b0, start} - {1'b0, `FBCI_REG_BASE};
    wire [16:0] end_off = start_off + {13'h0000, cnt};
    wire new_cmd = out_valid && (cmd != prev_cmd_ff);

    // ==========================================================
    // address arithmetic for the write and the window
    wire [16:0] wa_off = {1'b0, wr_addr_ff} - {1'b0, `FBCI_REG_BASE};
    wire wr_is_cmd = (wr_addr_ff == `FBCI_CMDREG_A) ||
                     (wr_addr_ff == `FBCI_CMDREG_B) ||
                     (wr_addr_ff == `FBCI_CMDREG_C);
    wire mem_we = state_ff[1] && !wr_is_cmd;
    wire [16:0] ra_sum = {1'b0, win_base_ff} + {15'h0000, rd_idx_ff};
    wire [16:0] ra_off = ra_sum - {1'b0, `FBCI_REG_BASE};
    // command locations hold nothing, so the window reads them as zero
    wire ra_is_cmd = (ra_sum[15:0] == `FBCI_CMDREG_A) ||
                     (ra_sum[15:0] == `FBCI_CMDREG_B) ||
                     (ra_sum[15:0] == `FBCI_CMDREG_C);
    wire ra_ok = !ra_off[16] && (ra_off < `FBCI_REG_DEPTH) &&
                 !ra_is_cmd;

    fbci_regmem u_mem (
        .ref_clk(ref_clk),
        .srst(srst),
        .wr_en(mem_we),
        .wr_addr(wa_off[`FBCI_AW-1:0]),
        .wr_data(wdat_ff[127:112]),
        .rd_addr(ra_off[`FBCI_AW-1:0]),
        .rd_data_ff(rd_data)
    );

    // ==========================================================
    // command sequencer
    always @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            prev_cmd_ff <= 8'h00;
            ack_ff <= 8'h00;
            cmd_err_ff <= `FBCI_ERR_NONE;
            win_base_ff <= `FBCI_REG_BASE;
            wr_left_ff <= 4'h0;
            wr_addr_ff <= 16'h0000;
            wdat_ff <= {`FBCI_WDAT_BITS{1'b0}};
            act_req_ff <= 1'b0;
            act_cmd_ff <= 8'h00;
            busy_ff <= 1'b0;
        end else begin
            act_req_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    // a change seen while busy is taken once idle again
                    if (new_cmd) begin
                        prev_cmd_ff <= cmd;
                        if (cmd == `FBCI_CMD_WRITE) begin
                            if (cnt_hi || cnt == 4'h0 ||
                                    cnt > `FBCI_MAX_REGS) begin
                                ack_ff <= `FBCI_ACK_FAIL;
                                cmd_err_ff <= `FBCI_ERR_COUNT;
                            end else if (start_off[16] ||
                                    end_off > `FBCI_REG_DEPTH) begin
                                ack_ff <= `FBCI_ACK_BADADDR;
                                cmd_err_ff <= `FBCI_ERR_ADDR;
                            end else begin
                                state_ff <= ST_WRITE;
                                busy_ff <= 1'b1;
                                wr_left_ff <= cnt;
                                wr_addr_ff <= start;
                                wdat_ff <= out_img[127:0];
                            end
                        end else if (cmd == `FBCI_CMD_RDWIN) begin
                            win_base_ff <= start;
                            ack_ff <= cmd;
                            cmd_err_ff <= `FBCI_ERR_NONE;
                        end else if (cmd == `FBCI_CMD_CLRRST) begin
                            ack_ff <= cmd;
                            cmd_err_ff <= `FBCI_ERR_NONE;
                        end else begin
                            state_ff <= ST_ACT;
                            busy_ff <= 1'b1;
                            act_req_ff <= 1'b1;
                            act_cmd_ff <= cmd;
                        end
                    end
                end
                ST_WRITE: begin
                    // one register per cycle, words leave msb first
                    wr_left_ff <= wr_left_ff - 4'h1;
                    wr_addr_ff <= wr_addr_ff + 16'h0001;
                    wdat_ff <= {wdat_ff[111:0], 16'h0000};
                    if (wr_left_ff == 4'h1) begin
                        state_ff <= ST_IDLE;
                        busy_ff <= 1'b0;
                        ack_ff <= `FBCI_CMD_WRITE;
                        cmd_err_ff <= `FBCI_ERR_NONE;
                    end
                end
                ST_ACT: begin
                    if (act_done) begin
                        state_ff <= ST_IDLE;
                        busy_ff <= 1'b0;
                        if (act_ok) begin
                            ack_ff <= act_cmd_ff;
                            cmd_err_ff <= `FBCI_ERR_NONE;
                        end else begin
                            ack_ff <= `FBCI_ACK_FAIL;
                            cmd_err_ff <= act_err;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    busy_ff <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // restart flag: a new restart beats a clear in the same cycle
    wire clr_rst = state_ff[0] && new_cmd && (cmd == `FBCI_CMD_CLRRST);
    always @(posedge ref_clk) begin
        if (srst) begin
            restart_ff <= 1'b0;
        end else if (restart_set) begin
            restart_ff <= 1'b1;
        end else if (clr_rst) begin
            restart_ff <= 1'b0;
        end
    end

    // ==========================================================
    // window refresh: round robin over the window slots
    always @(posedge ref_clk) begin
        if (srst) begin
            rd_idx_ff <= 2'h0;
            rd_slot_ff <= 2'h0;
            rd_ok_ff <= 1'b0;
        end else begin
            // stop one short in the small mapping to keep refresh fast
            if (rd_idx_ff == `FBCI_LAST_SLOT ||
                    (!map86 && rd_idx_ff == 2'h2)) begin
                rd_idx_ff <= 2'h0;
            end else begin
                rd_idx_ff <= rd_idx_ff + 2'h1;
            end
            rd_slot_ff <= rd_idx_ff;
            rd_ok_ff <= ra_ok;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `FBCI_WIN_REGS; gi = gi + 1) begin : g_win
            reg [15:0] win_ff;
            always @(posedge ref_clk) begin
                if (srst) begin
                    win_ff <= 16'h0000;
                end else if (rd_slot_ff == gi) begin
                    // outside the store the window reads as zero
                    win_ff <= rd_ok_ff ? rd_data : 16'h0000;
                end
            end
            assign win_w[gi] = win_ff;
        end
    endgenerate

    // ==========================================================
    // input image, most significant byte at the lower address
    wire [15:0] st2 = {status2[15:`FBCI_RESTART_BIT+1], restart_ff,
                       status2[`FBCI_RESTART_BIT-1:0]};
    wire [`FBCI_TAIL_BITS-1:0] tail86 = {win_w[3], cmd_err_ff,
                                         float_data};
    wire [`FBCI_TAIL_BITS-1:0] tail = map86 ? tail86 :
                                      {`FBCI_TAIL_BITS{1'b0}};

    always @(posedge ref_clk) begin
        if (srst) begin
            in_img_ff <= {`FBCI_IN_BITS{1'b0}};
        end else begin
            in_img_ff <= {ack_ff, inst_err, disp_weight, status1, st2,
                          win_base_ff, win_w[0], win_w[1], win_w[2],
                          tail};
        end
    end
endmodule // fbci_core

// ===== core/fbci_defines.vh
// shared constants of the fieldbus command interpreter
`ifndef FBCI_DEFINES_VH
`define FBCI_DEFINES_VH

// ==========================================================
// image sizes
`define FBCI_OUT_BITS 160
`define FBCI_IN_BITS 688
`define FBCI_TAIL_BITS 528
`define FBCI_FLT_BITS 480
`define FBCI_WDAT_BITS 128

// ==========================================================
// commands and acknowledge codes
`define FBCI_CMD_WRITE 8'hc8
`define FBCI_CMD_RDWIN 8'hc9
`define FBCI_CMD_CLRRST 8'hca
`define FBCI_ACK_BADADDR 8'hfe
`define FBCI_ACK_FAIL 8'hff
`define FBCI_MAX_REGS 4'h8

// ==========================================================
// detailed command error codes
`define FBCI_ERR_NONE 32'h0000_0000
`define FBCI_ERR_COUNT 32'h0000_0001
`define FBCI_ERR_ADDR 32'h0000_0002

// ==========================================================
// register space held by the interpreter
`define FBCI_REG_BASE 16'h9c41
`define FBCI_REG_DEPTH 17'h00100
`define FBCI_AW 8
`define FBCI_CMDREG_A 16'h9c5e
`define FBCI_CMDREG_B 16'h9d28
`define FBCI_CMDREG_C 16'h9d29
`define FBCI_RESTART_BIT 4
`define FBCI_WIN_REGS 4
`define FBCI_LAST_SLOT 2'h3

`endif

// ===== core/fbci_regmem.v
// register store written by command 200 and read by the window
`timescale 1ns/100ps
`include "fbci_defines.vh"

module fbci_regmem (
    ref_clk,
    srst,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr,
    rd_data_ff
);
    input wire ref_clk;
    input wire srst;
    input wire wr_en;
    input wire [`FBCI_AW-1:0] wr_addr;
    input wire [15:0] wr_data;
    input wire [`FBCI_AW-1:0] rd_addr;
    output reg [15:0] rd_data_ff;

    reg [15:0] mem [0:(1<<`FBCI_AW)-1];

    // ==========================================================
    // write port and registered read port
    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            rd_data_ff <= 16'h0000;
        end else begin
            rd_data_ff <= mem[rd_addr];
        end
    end
endmodule // fbci_regmem

// ===== verification/fbci_core_properties.sv
// assertions on the ports of the command interpreter
`timescale 1ns/100ps
`include "fbci_defines.vh"
// ========
// checker
module fbci_core_properties (
    input wire ref_clk,
    input wire srst,
    input wire [`FBCI_OUT_BITS-1:0] out_img,
    input wire out_valid,
    input wire [7:0] inst_err,
    input wire [47:0] disp_weight,
    input wire [15:0] status1,
    input wire restart_set,
    input wire act_done,
    input wire act_ok,
    input wire act_req_ff,
    input wire [7:0] act_cmd_ff,
    input wire busy_ff,
    input wire [`FBCI_IN_BITS-1:0] in_img_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire [7:0] ack = in_img_ff[687:680];
    req_pulse_a: assert property (act_req_ff |=> !act_req_ff)
        else $error("action request longer than one cycle");
    req_cmd_a: assert property (act_req_ff |-> busy_ff &&
        act_cmd_ff == $past(out_img[159:152]))
        else $error("action request not for the taken command");
    err_byte_a: assert property (!$past(srst) |->
        in_img_ff[679:672] == $past(inst_err))
        else $error("error byte does not follow instrument");
    weight_bytes_a: assert property (!$past(srst) |->
        in_img_ff[671:624] == $past(disp_weight))
        else $error("weight bytes wrong");
    status_one_a: assert property (!$past(srst) |->
        in_img_ff[623:608] == $past(status1))
        else $error("status 1 bytes wrong");
    ack_hold_a: assert property (!busy_ff && !$past(busy_ff) &&
        !$past(busy_ff, 2) && !$past(busy_ff, 3) && !$past(out_valid)
        && !$past(out_valid, 2) |-> $stable(ack))
        else $error("acknowledge changed without a command");
    act_fail_a: assert property (act_done && !act_ok && busy_ff
        |-> ##2 ack == 8'hff) else $error("failed action not 255");
    act_ok_a: assert property (act_done && act_ok && busy_ff
        |-> ##2 ack == $past(act_cmd_ff, 2))
        else $error("done action not acknowledged");
    restart_clr_a: assert property ($changed(ack) && ack == 8'hca &&
        !$past(restart_set) && !$past(restart_set, 2) |-> !in_img_ff[596])
        else $error("restart flag not cleared");
endmodule // fbci_core_properties

bind fbci_core fbci_core_properties u_fbci_core_properties (
    .ref_clk(ref_clk), .srst(srst), .out_img(out_img),
    .out_valid(out_valid),
    .inst_err(inst_err), .disp_weight(disp_weight), .status1(status1),
    .restart_set(restart_set), .act_done(act_done), .act_ok(act_ok),
    .act_req_ff(act_req_ff), .act_cmd_ff(act_cmd_ff), .busy_ff(busy_ff),
    .in_img_ff(in_img_ff));

// ===== verification/fbci_instr_model.sv
// instrument model answering action requests of the interpreter
`timescale 1ns/100ps
// ========
// action responder
module fbci_instr_model (
    input wire ref_clk,
    input wire act_req,
    input wire [7:0] act_cmd,
    input wire [3:0] lat,
    input wire fail_en,
    output logic act_done,
    output logic act_ok,
    output logic [31:0] act_err
);
    logic [4:0] cnt_ff = 5'h00;
    logic [7:0] cmd_ff = 8'h00;
    initial {act_done, act_ok, act_err} = '0;
    // ok and detail toggle while idle so stale values never look valid
    always @(posedge ref_clk) begin
        act_done <= 1'b0;
        act_ok <= ~act_ok;
        act_err <= ~act_err;
        if (act_req) begin
            cnt_ff <= {1'b0, lat} + 5'h01;
            cmd_ff <= act_cmd;
        end else if (cnt_ff != 5'h00) begin
            cnt_ff <= cnt_ff - 5'h01;
            if (cnt_ff == 5'h01) begin
                act_done <= 1'b1;
                act_ok <= ~fail_en;
                act_err <= {24'h000000, cmd_ff};
            end
        end
    end
endmodule // fbci_instr_model

// ===== verification/tb_fbci_core.sv
// self-checking bench of the command interpreter
`timescale 1ns/100ps
`include "fbci_defines.vh"
// ========
// bench
module tb_fbci_core;
    logic ref_clk = 1'b0, srst = 1'b1, map86 = 1'b1, out_valid = 1'b0;
    logic [`FBCI_OUT_BITS-1:0] out_img = '0;
    logic [7:0] inst_err = 8'h00;
    logic [47:0] disp_weight = '0;
    logic [15:0] status1 = 16'h0000, status2 = 16'h0000;
    logic [`FBCI_FLT_BITS-1:0] float_data = '0;
    logic restart_set = 1'b0, fail_en = 1'b0;
    logic [3:0] lat = 4'h0;
    wire act_done, act_ok, act_req_ff, busy_ff;
    wire [31:0] act_err;
    wire [7:0] act_cmd_ff;
    wire [`FBCI_IN_BITS-1:0] in_img_ff;
    int bad_count = 0, num_checks = 0;
    logic [7:0] exp_q[$];
    logic [7:0] last_ack = 8'h00;
    logic [71:0] p_in;
    logic [15:0] p_s2;
    logic rst_s = 1'b1;
    logic [479:0] p_fl;
    logic [127:0] d;
    logic [511:0] r;
    logic [31:0] seed = 32'h7d163a8d;
    fbci_core u_fbci_core (.ref_clk(ref_clk), .srst(srst), .map86(map86),
        .out_valid(out_valid), .out_img(out_img), .inst_err(inst_err),
        .disp_weight(disp_weight), .status1(status1), .status2(status2),
        .float_data(float_data), .restart_set(restart_set),
        .act_done(act_done), .act_ok(act_ok), .act_err(act_err),
        .act_req_ff(act_req_ff), .act_cmd_ff(act_cmd_ff),
        .busy_ff(busy_ff), .in_img_ff(in_img_ff));
    fbci_instr_model u_fbci_instr_model (.ref_clk(ref_clk),
        .act_req(act_req_ff), .act_cmd(act_cmd_ff), .lat(lat),
        .fail_en(fail_en), .act_done(act_done), .act_ok(act_ok),
        .act_err(act_err));
    always #5 ref_clk = ~ref_clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input [479:0] e, input [479:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic complete_run;
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // master duty: whole image stands before and after the command edge
    task automatic send(input [7:0] c, input [7:0] n, input [15:0] a,
            input [127:0] dd, input [7:0] e, input bit p);
        int k = 0;
        if (p) exp_q.push_back(e);
        @(posedge ref_clk);
        #1 out_img = {c, n, a, dd};
        out_valid = 1'b1;
        @(posedge ref_clk);
        #1 out_valid = 1'b0;
        repeat (2) @(posedge ref_clk);
        while (busy_ff !== 1'b0 && k < 40) begin
            @(posedge ref_clk);
            k++;
        end
        repeat (8) @(posedge ref_clk);
        #2;
    endtask
    // status inputs change every cycle so a stale image byte shows up
    always @(posedge ref_clk) begin
        #1;
        for (int i = 0; i < 16; i++) r[i*32 +: 32] = rnd();
        {inst_err, disp_weight, status1, status2} = r[87:0];
        float_data = r[511:32];
    end
    always @(posedge ref_clk) begin
        rst_s <= srst;
        p_in <= {inst_err, disp_weight, status1};
        p_s2 <= status2;
        p_fl <= map86 ? float_data : 480'h0;
        #2;
        // reset as sampled at the edge, not as released after it
        if (!rst_s) begin
            cmp(p_in, in_img_ff[679:608]);
            cmp(p_s2 & 16'hffef, in_img_ff[607:592] & 16'hffef);
            cmp(p_fl, in_img_ff[479:0]);
            if (in_img_ff[687:680] !== last_ack) begin
                last_ack = in_img_ff[687:680];
                if (exp_q.size() == 0) cmp(~last_ack, last_ack);
                else cmp(exp_q.pop_front(), last_ack);
            end
        end
    end
    initial begin
        #20000;
        bad_count++;
        complete_run;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        #1 srst = 1'b0;
        @(posedge ref_clk);
        #1 restart_set = 1'b1;
        cmp(16'h9c41, in_img_ff[591:576]);
        @(posedge ref_clk);
        #1 restart_set = 1'b0;
        repeat (3) @(posedge ref_clk);
        #2 cmp(1'b1, in_img_ff[596]);
        send(8'hca, 8'h00, 16'h0000, '0, 8'hca, 1);
        cmp(1'b0, in_img_ff[596]);
        send(8'hc9, 8'h00, 16'h9c49, '0, 8'hc9, 1);
        cmp(16'h9c49, in_img_ff[591:576]);
        d = {rnd(), rnd(), rnd(), rnd()};
        send(8'hc8, 8'h08, 16'h9c49, d, 8'hc8, 1);
        cmp(d[127:64], in_img_ff[575:512]);
        send(8'hc8, 8'h08, 16'h9c49, ~d, 8'hc8, 0);
        cmp(d[127:64], in_img_ff[575:512]);
        lat = 4'h7;
        send(8'h09, 8'h00, 16'h0000, '0, 8'h09, 1);
        send(8'hc8, 8'h09, 16'h9c49, d, 8'hff, 1);
        cmp(32'h1, in_img_ff[511:480]);
        send(8'hc9, 8'h00, 16'h9c5d, '0, 8'hc9, 1);
        d = {64'h1111_2222_3333_4444, 64'h0};
        send(8'hc8, 8'h04, 16'h9c5d, d, 8'hc8, 1);
        cmp(64'h1111_0000_3333_4444, in_img_ff[575:512]);
        lat = 4'h0;
        send(8'h00, 8'h00, 16'h0000, '0, 8'h00, 1);
        send(8'hc8, 8'h02, 16'h9d40, d, 8'hfe, 1);
        cmp(32'h2, in_img_ff[511:480]);
        fail_en = 1'b1;
        send(8'h33, 8'h00, 16'h0000, '0, 8'hff, 1);
        cmp(32'h33, in_img_ff[511:480]);
        d = {48'h0000_00c8_0001, 80'h0};
        send(8'hc8, 8'h03, 16'h9c5f, d, 8'hc8, 1);
        cmp(64'h1111_0000_0000_00c8, in_img_ff[575:512]);
        map86 = 1'b0;
        repeat (8) @(posedge ref_clk);
        #2 cmp(16'h0, in_img_ff[527:512]);
        cmp(0, exp_q.size());
        complete_run;
    end
endmodule // tb_fbci_core
